// >>> dias_alarm_monitor.sv
`timescale 1ns/1ps
`include "dias_defines.vh"
module dias_alarm_monitor (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire [7:0]  s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire [15:0] dac_data_in,
   input wire [15:0] dac_data_out
);
   // remember the read address, the answer does not carry it
   reg  [7:0] ra_r;
   wire       aw = s_axi_awvalid && s_axi_awready;
   wire       wt = s_axi_wvalid && s_axi_wready;
   wire       ar = s_axi_arvalid && s_axi_arready;
   wire       st = ra_r == `DIAS_ADDR_STATUS;
   wire       um = !st && ra_r != `DIAS_ADDR_MASK && ra_r != `DIAS_ADDR_SHUT;
   always @(posedge aclk) begin
      if (ar)
         ra_r <= s_axi_araddr;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_aw_busy: assert property (aw |=> !s_axi_awready)
      else $error("write address taken while busy");
   a_ar_busy: assert property (ar |=> !s_axi_arready)
      else $error("read address taken while busy");
   a_b_answer: assert property (aw && wt |-> ##2 s_axi_bvalid)
      else $error("write response not on time");
   a_r_answer: assert property (ar |=> s_axi_rvalid)
      else $error("read data not on time");
   a_resv_zero: assert property (s_axi_rvalid && st |->
      (s_axi_rdata & {16'hffff, `DIAS_RESV_MASK}) == 0)
      else $error("reserved status bit set");
   a_out_or: assert property (s_axi_rvalid && st &&
      |{s_axi_rdata[13], s_axi_rdata[10:9]} |-> s_axi_rdata[8])
      else $error("shutdown bit missing");
   a_unmapped: assert property (s_axi_rvalid && um |->
      s_axi_rresp == `DIAS_RESP_SLVERR && s_axi_rdata == 0)
      else $error("unmapped read not refused");
   a_out_mid: assert property (dac_data_out == `DIAS_MIDSCALE ||
      dac_data_out == $past(dac_data_in))
      else $error("output neither data nor midscale");
endmodule
bind dias_alarm_status dias_alarm_monitor i_mon (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .dac_data_in, .dac_data_out);

// >>> dias_alarm_status.v
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dias_defines.vh"
module dias_alarm_status #(
   parameter PTR_W = 8
) (
   input  wire             aclk,
   input  wire             aresetn,
   input  wire [7:0]       s_axi_awaddr,
   input  wire             s_axi_awvalid,
   output reg              s_axi_awready,
   input  wire [31:0]      s_axi_wdata,
   input  wire [3:0]       s_axi_wstrb,
   input  wire             s_axi_wvalid,
   output reg              s_axi_wready,
   output reg  [1:0]       s_axi_bresp,
   output reg              s_axi_bvalid,
   input  wire             s_axi_bready,
   input  wire [7:0]       s_axi_araddr,
   input  wire             s_axi_arvalid,
   output reg              s_axi_arready,
   output reg  [31:0]      s_axi_rdata,
   output reg  [1:0]       s_axi_rresp,
   output reg              s_axi_rvalid,
   input  wire             s_axi_rready,
   input  wire [PTR_W-1:0] wr_ptr_sr,
   input  wire [2:0]       fifo_near,
   input  wire             sample_clk_lost,
   input  wire             data_clk_lost,
   input  wire             pattern_fail,
   input  wire             pll_unlock,
   input  wire             rise_parity_err,
   input  wire             fall_parity_err,
   input  wire             frame_parity_err,
   input  wire [15:0]      dac_data_in,
   output reg  [15:0]      dac_data_out,
   output reg              alarm_any
);

   // raw conditions arrive from other clock domains: two flops each
   reg  [PTR_W-1:0] ptr_s1_r;
   reg  [PTR_W-1:0] ptr_s2_r;
   reg  [2:0]       near_s1_r;
   reg  [2:0]       near_s2_r;
   reg  [6:0]       ev_s1_r;
   reg  [6:0]       ev_s2_r;
   // sticky alarm bits, one flop each
   reg              zero_r;
   reg              coll_r;
   reg              one_r;
   reg              two_r;
   reg              sclk_r;
   reg              dclk_r;
   reg              out_r;
   reg              pat_r;
   reg              pll_r;
   reg              rpar_r;
   reg              fpar_r;
   reg              frpar_r;
   reg  [15:0]      mask_r;
   reg  [2:0]       shut_en_r;
   reg  [7:0]       aw_r;
   reg  [31:0]      wd_r;
   reg  [3:0]       ws_r;
   reg              aw_ok_r;
   reg              w_ok_r;
   wire             zero_set;
   wire             coll_set;
   wire             one_set;
   wire             two_set;
   wire             sclk_set;
   wire             dclk_set;
   wire             out_gone;
   wire             pat_set;
   wire             pll_set;
   wire             rpar_set;
   wire             fpar_set;
   wire             frpar_set;
   wire [15:0]      stat_img;
   wire [15:0]      clr;
   wire             do_wr;
   wire             shut_now;

   // byte address with the two lane bits dropped
   function [7:0] word_addr;
      input [7:0] addr;
      begin
         word_addr = {addr[7:2], 2'b00};
      end
   endfunction

   // true when an aligned address names one of the three registers
   function reg_mapped;
      input [7:0] addr;
      begin
         reg_mapped = (addr == `DIAS_ADDR_STATUS) ||
                      (addr == `DIAS_ADDR_MASK) ||
                      (addr == `DIAS_ADDR_SHUT);
      end
   endfunction

   // write-one-to-clear bits, only from lanes whose strobe is set
   function [15:0] clr_bits;
      input [3:0]  strb;
      input [31:0] data;
      begin
         clr_bits = {strb[1] ? data[15:8] : 8'h00,
                     strb[0] ? data[7:0]  : 8'h00};
      end
   endfunction

   // next value of one sticky bit: a set in the clearing cycle wins
   function sticky;
      input old;
      input set;
      input clear;
      begin
         sticky = set | (old & ~clear);
      end
   endfunction

   // pointer word: bits are not sampled together, so a moving pointer
   // may briefly look all zero; only a stuck pointer is meaningful
   always @(posedge aclk) begin
      ptr_s1_r <= wr_ptr_sr;
      ptr_s2_r <= ptr_s1_r;
   end

   // fifo nearness levels
   always @(posedge aclk) begin
      near_s1_r <= fifo_near;
      near_s2_r <= near_s1_r;
   end

   // single-bit alarm sources, pulses must last one clock to be seen
   always @(posedge aclk) begin
      ev_s1_r <= {sample_clk_lost, data_clk_lost, pattern_fail,
                  pll_unlock, rise_parity_err, fall_parity_err,
                  frame_parity_err};
      ev_s2_r <= ev_s1_r;
   end

   // map synchronised conditions onto their status bits
   assign zero_set  = (ptr_s2_r == {PTR_W{1'b0}});
   assign coll_set  = near_s2_r[2];
   assign one_set   = near_s2_r[1] & ~near_s2_r[2];
   assign two_set   = near_s2_r[0] & ~near_s2_r[1] & ~near_s2_r[2];
   assign sclk_set  = ev_s2_r[6];
   assign dclk_set  = ev_s2_r[5];
   assign out_gone  = sclk_set | dclk_set | coll_set;
   assign pat_set   = ev_s2_r[4];
   assign pll_set   = ev_s2_r[3];
   assign rpar_set  = ev_s2_r[2];
   assign fpar_set  = ev_s2_r[1];
   assign frpar_set = ev_s2_r[0];

   // write channel: address and data captured in either order
   assign do_wr = aw_ok_r & w_ok_r & ~s_axi_bvalid;
   assign clr   = (do_wr && aw_r == `DIAS_ADDR_STATUS) ?
                  clr_bits(ws_r, wd_r) : 16'h0000;

   // pointer all zeros: write side stuck until resync
   always @(posedge aclk) begin
      if (!aresetn)
         zero_r <= 1'b0;
      else
         zero_r <= sticky(zero_r, zero_set, clr[`DIAS_B_ZERO]);
   end

   // pointer collision
   always @(posedge aclk) begin
      if (!aresetn)
         coll_r <= 1'b0;
      else
         coll_r <= sticky(coll_r, coll_set, clr[`DIAS_B_COLL]);
   end

   // pointers one apart
   always @(posedge aclk) begin
      if (!aresetn)
         one_r <= 1'b0;
      else
         one_r <= sticky(one_r, one_set, clr[`DIAS_B_ONE]);
   end

   // pointers two apart
   always @(posedge aclk) begin
      if (!aresetn)
         two_r <= 1'b0;
      else
         two_r <= sticky(two_r, two_set, clr[`DIAS_B_TWO]);
   end

   // converter sample clock stopped
   always @(posedge aclk) begin
      if (!aresetn)
         sclk_r <= 1'b0;
      else
         sclk_r <= sticky(sclk_r, sclk_set, clr[`DIAS_B_SCLK]);
   end

   // input data clock stopped
   always @(posedge aclk) begin
      if (!aresetn)
         dclk_r <= 1'b0;
      else
         dclk_r <= sticky(dclk_r, dclk_set, clr[`DIAS_B_DCLK]);
   end

   // output shutdown summary, set by the raw or of its causes
   always @(posedge aclk) begin
      if (!aresetn)
         out_r <= 1'b0;
      else
         out_r <= sticky(out_r, out_gone, clr[`DIAS_B_OUT]);
   end

   // pattern mismatch
   always @(posedge aclk) begin
      if (!aresetn)
         pat_r <= 1'b0;
      else
         pat_r <= sticky(pat_r, pat_set, clr[`DIAS_B_PAT]);
   end

   // pll lost lock
   always @(posedge aclk) begin
      if (!aresetn)
         pll_r <= 1'b0;
      else
         pll_r <= sticky(pll_r, pll_set, clr[`DIAS_B_PLL]);
   end

   // rising edge parity
   always @(posedge aclk) begin
      if (!aresetn)
         rpar_r <= 1'b0;
      else
         rpar_r <= sticky(rpar_r, rpar_set, clr[`DIAS_B_RPAR]);
   end

   // falling edge parity
   always @(posedge aclk) begin
      if (!aresetn)
         fpar_r <= 1'b0;
      else
         fpar_r <= sticky(fpar_r, fpar_set, clr[`DIAS_B_FPAR]);
   end

   // frame bit parity
   always @(posedge aclk) begin
      if (!aresetn)
         frpar_r <= 1'b0;
      else
         frpar_r <= sticky(frpar_r, frpar_set, clr[`DIAS_B_FRPAR]);
   end

   // status image; alarms restart from zero, the part has no fixed value
   assign stat_img = {zero_r, 1'b0, coll_r, one_r, two_r, sclk_r, dclk_r,
                      out_r, pat_r, 1'b0, pll_r, rpar_r, fpar_r, frpar_r,
                      2'b00};

   // shutdown forces midscale while enabled causes remain latched
   assign shut_now = (shut_en_r[0] & sclk_r) |
                     (shut_en_r[1] & dclk_r) |
                     (shut_en_r[2] & coll_r);

   // software settings: alarm mask and shutdown enables
   always @(posedge aclk) begin
      if (!aresetn) begin
         mask_r    <= `DIAS_MASK_RST;
         shut_en_r <= `DIAS_SHUT_RST;
      end else begin
         if (do_wr && aw_r == `DIAS_ADDR_MASK) begin
            if (ws_r[0]) mask_r[7:0]  <= wd_r[7:0];
            if (ws_r[1]) mask_r[15:8] <= wd_r[15:8];
         end
         if (do_wr && aw_r == `DIAS_ADDR_SHUT && ws_r[0])
            shut_en_r <= wd_r[2:0];
      end
   end

   // outputs; a live cause also forces midscale while any shutdown enable
   // is set, so the converter is quiet in the same cycle the bit latches
   always @(posedge aclk) begin
      if (!aresetn) begin
         dac_data_out <= `DIAS_MIDSCALE;
         alarm_any    <= 1'b0;
      end else begin
         alarm_any    <= |(stat_img & ~mask_r);
         dac_data_out <= (shut_now | (out_gone & |shut_en_r)) ?
                         `DIAS_MIDSCALE : dac_data_in;
      end
   end

   // axi write handshake, one transfer at a time
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `DIAS_RESP_OKAY;
         aw_ok_r       <= 1'b0;
         w_ok_r        <= 1'b0;
         aw_r          <= 8'h00;
         wd_r          <= 32'h00000000;
         ws_r          <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_r          <= word_addr(s_axi_awaddr);
            aw_ok_r       <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd_r         <= s_axi_wdata;
            ws_r         <= s_axi_wstrb;
            w_ok_r       <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_wr) begin
            aw_ok_r      <= 1'b0;
            w_ok_r       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= reg_mapped(aw_r) ?
                            `DIAS_RESP_OKAY : `DIAS_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // axi read: one cycle after the address is taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `DIAS_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `DIAS_RESP_OKAY;
            case (word_addr(s_axi_araddr))
               `DIAS_ADDR_STATUS: s_axi_rdata <= {16'h0000, stat_img};
               `DIAS_ADDR_MASK:   s_axi_rdata <= {16'h0000, mask_r};
               `DIAS_ADDR_SHUT:   s_axi_rdata <= {29'h0, shut_en_r};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `DIAS_RESP_SLVERR;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

// >>> dias_defines.vh
// Function
// - set bit 15 when the fifo write pointer shift register is all zeros
// - bits 13:11 report pointers two apart, one apart or colliding
// - set bit 10 when the converter sample clock has stopped
// - set bit 9 when the input data clock has stopped
// - bit 8 is or of clock losses and collision; outputs then midscale (here only while a shutdown enable is set)
// - set bit 7 when received pattern differs from programmed pattern
// - set bit 5 when the pll loses lock
// - set bit 4 on rising edge data parity error
// - set bit 3 on falling edge data parity error
// - set bit 2 on frame bit parity error
// - alarm bits have no fixed reset value and clear by software write (here they reset to zero)
// - bits 14, 6, 1 and 0 are reserved and never alarm
// - a 16-bit mask register suppresses masked alarms, reset all masked
`ifndef DIAS_DEFINES_VH
`define DIAS_DEFINES_VH
`define DIAS_IDX_STATUS   8'h05
`define DIAS_IDX_MASK     8'h07
`define DIAS_IDX_SHUT     8'h08
`define DIAS_ADDR_STATUS  8'h14
`define DIAS_ADDR_MASK    8'h1c
`define DIAS_ADDR_SHUT    8'h20
`define DIAS_MASK_RST     16'hffff
`define DIAS_SHUT_RST     3'h0
`define DIAS_MIDSCALE     16'h8000
`define DIAS_B_ZERO       15
`define DIAS_B_COLL       13
`define DIAS_B_ONE        12
`define DIAS_B_TWO        11
`define DIAS_B_SCLK       10
`define DIAS_B_DCLK       9
`define DIAS_B_OUT        8
`define DIAS_B_PAT        7
`define DIAS_B_PLL        5
`define DIAS_B_RPAR       4
`define DIAS_B_FPAR       3
`define DIAS_B_FRPAR      2
`define DIAS_RESV_MASK    16'h4043
`define DIAS_RESP_OKAY    2'b00
`define DIAS_RESP_SLVERR  2'b10
`endif

// >>> tb_dias_alarm_status.sv
`timescale 1ns/1ps
`include "dias_defines.vh"
module tb_dias_alarm_status;
   logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [10:0] ev = 0;
   logic [15:0] dac_data_in = 16'h1234;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire         s_axi_rvalid, alarm_any;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire  [15:0] dac_data_out;
   integer      mismatches = 0, num_checks = 0, cyc = 0, i;
   logic [15:0] eb [0:10] = '{16'h0500, 16'h0300, 16'h0080, 16'h0020,
      16'h0010, 16'h0008, 16'h0004, 16'h0800, 16'h1000, 16'h2100, 16'h8000};
   // ev drives one alarm source per bit, pointer all zeros on bit 10
   dias_alarm_status i_dias_alarm_status (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .wr_ptr_sr(ev[10] ? 8'h00 : 8'h01), .fifo_near(ev[9:7]),
      .sample_clk_lost(ev[0]), .data_clk_lost(ev[1]),
      .pattern_fail(ev[2]), .pll_unlock(ev[3]), .rise_parity_err(ev[4]),
      .fall_parity_err(ev[5]), .frame_parity_err(ev[6]), .dac_data_in,
      .dac_data_out, .alarm_any);
   // free running clock, 50 ns period
   initial begin
      forever #25 aclk = ~aclk;
   end
   // hang guard, far above the few hundred cycles the tests need
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches = mismatches + 1;
         test_done;
      end
   end
   task test_done;
      if (mismatches == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input string n, input [31:0] e, input [31:0] g);
      num_checks = num_checks + 1;
      if (g !== e) begin
         mismatches = mismatches + 1;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   // address and data offered together, each dropped once taken
   task wr(input [7:0] a, input [31:0] d, input [1:0] e);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", e, s_axi_bresp);
   endtask
   task rd(input [7:0] a, input [31:0] e, input [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
   endtask
   task t_reset;
      rd(`DIAS_ADDR_STATUS, 0, `DIAS_RESP_OKAY);
      rd(`DIAS_ADDR_MASK, 32'h0000ffff, `DIAS_RESP_OKAY);
      chk("dac_data_out", 16'h1234, dac_data_out);
   endtask
   // each source pulses, then must stay latched until cleared
   task t_events;
      for (i = 0; i < 11; i = i + 1) begin
         ev <= 11'h1 << i;
         repeat (5) @(posedge aclk);
         ev <= 0;
         rd(`DIAS_ADDR_STATUS, eb[i], `DIAS_RESP_OKAY);
         chk("alarm_any", 0, alarm_any);
         wr(`DIAS_ADDR_STATUS, 32'h0000ffff, `DIAS_RESP_OKAY);
         rd(`DIAS_ADDR_STATUS, 0, `DIAS_RESP_OKAY);
      end
   endtask
   // one enabled cause latched holds midscale until software clears it
   task t_shut(input [2:0] en, input [10:0] src);
      wr(`DIAS_ADDR_SHUT, {29'h0, en}, `DIAS_RESP_OKAY);
      ev <= src;
      repeat (5) @(posedge aclk);
      ev <= 0;
      repeat (3) @(posedge aclk);
      chk("dac_data_out", `DIAS_MIDSCALE, dac_data_out);
      chk("alarm_any", 1, alarm_any);
      wr(`DIAS_ADDR_STATUS, 32'h0000ffff, `DIAS_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("dac_data_out", 16'h1234, dac_data_out);
      chk("alarm_any", 0, alarm_any);
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_events;
      wr(`DIAS_ADDR_MASK, 0, `DIAS_RESP_OKAY);
      t_shut(3'h1, 11'h001);
      t_shut(3'h2, 11'h002);
      t_shut(3'h4, 11'h200);
      rd(8'h00, 0, `DIAS_RESP_SLVERR);
      wr(8'h00, 32'h0000ffff, `DIAS_RESP_SLVERR);
      test_done;
   end
endmodule
